// file: hdl/ipc_cfg.svh
// Purpose: Offsets, field positions, reset values of the pin config block
// Assumes: Byte-wide registers on the internal register port
// Notes: Included by the design modules
`ifndef IPC_CFG_SVH
`define IPC_CFG_SVH
// Register offsets
`define IPC_OFS_COMM_CTRL 8'h31
`define IPC_OFS_PIN_CFG 8'h33
`define IPC_OFS_INT_STATUS 8'h14
// Communication control fields
`define IPC_BIT_SWAP 4
`define IPC_BIT_THREE_WIRE 5
`define IPC_BIT_INDIV_CLR 6
`define IPC_COMM_RD_MASK 8'hfc
// Pin configuration fields
`define IPC_BIT_A_HIGH 2
`define IPC_BIT_A_PP 3
`define IPC_BIT_B_HIGH 6
`define IPC_BIT_B_PP 7
// Reset values
`define IPC_RST_COMM 8'h00
`define IPC_RST_PIN 8'h00
`define IPC_RST_STATUS 8'h00
`endif

// file: hdl/ipc_pkg.sv
// Purpose: Shared types of the interrupt pin config block
// Assumes: Constants come from ipc_cfg.svh
// Notes: Types only
package ipc_pkg;
  typedef logic [7:0] ipc_byte_type;
  typedef enum logic [1:0] {
    IPC_PIN_IDLE = 2'b00,
    IPC_PIN_ASSERT = 2'b01
  } ipc_pin_state_type;
endpackage : ipc_pkg

// file: hdl/ipc_pin_drv.sv
// Purpose: One interrupt pin driver with polarity and drive mode
// Assumes: Request level is synchronous to core_clk_i
// Notes: Output enable is low while the pin is driven
`timescale 1ns/1ns
`include "ipc_cfg.svh"
module ipc_pin_drv
  import ipc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Control
  input wire logic req_i,
  input wire logic active_high_i,
  input wire logic push_pull_i,
  // Pin
  output logic pin_o,
  output logic pin_oe_n_o,
  output logic asserted_o
);
  ipc_pin_state_type state_r, state_nxt;
  logic pin_r, pin_nxt, oe_n_r, oe_n_nxt;

  // Next pin level and enable
  always_comb
  begin
    state_nxt = req_i ? IPC_PIN_ASSERT : IPC_PIN_IDLE;
    // Active level chosen by polarity bit
    pin_nxt = req_i ~^ active_high_i;
    // Open drain drives only the low level
    oe_n_nxt = push_pull_i ? 1'b0 : pin_nxt;
  end

  // Register pin state
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      state_r <= IPC_PIN_IDLE;
      pin_r <= 1'b1;
      oe_n_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      pin_r <= pin_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  assign pin_o = pin_r;
  assign pin_oe_n_o = oe_n_r;
  assign asserted_o = (state_r == IPC_PIN_ASSERT);
endmodule : ipc_pin_drv

// file: hdl/ipc_top.sv
// Purpose: Interrupt pin routing, clear modes and serial pin option
// Assumes: Register port and event inputs synchronous to core_clk_i
// Notes: Event flags come from the motion engines as pulses
`timescale 1ns/1ns
`include "ipc_cfg.svh"
module ipc_top
  import ipc_pkg::*;
#(
  parameter int unsigned GROUP_A_MASK = 8'h0f
)
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Motion event pulses
  input wire logic [7:0] event_set_i,
  // Serial data out path
  input wire logic serial_tx_data_i,
  input wire logic serial_tx_en_i,
  input wire logic serial_out_pin_i,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe_n_o,
  output logic serial_rx_data_o,
  output logic three_wire_enable_o,
  // Interrupt pins
  output logic irq_pin_a_o,
  output logic irq_pin_a_oe_n_o,
  output logic irq_pin_b_o,
  output logic irq_pin_b_oe_n_o
);
  ipc_byte_type comm_r, comm_nxt, pin_cfg_r, pin_cfg_nxt;
  ipc_byte_type status_r, status_nxt, rdata_r, rdata_nxt;
  logic sout_r, sout_nxt, soe_n_r, soe_n_nxt, srx_r, srx_nxt;
  logic request_group_a, request_group_b, req_a, req_b;
  logic a_asserted, b_asserted;
  logic irq_pin_swap, three_wire_enable, individual_clear_enable;

  // Mask must fit the eight status flags
  if (GROUP_A_MASK > 32'hff)
  begin : g_bad_mask
    $error("GROUP_A_MASK exceeds eight flags");
  end

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  assign irq_pin_swap = comm_r[`IPC_BIT_SWAP];
  assign three_wire_enable = comm_r[`IPC_BIT_THREE_WIRE];
  assign individual_clear_enable = comm_r[`IPC_BIT_INDIV_CLR];

  // Register writes and status flags, set beats clear
  always_comb
  begin
    comm_nxt = comm_r;
    pin_cfg_nxt = pin_cfg_r;
    status_nxt = status_r;
    if (reg_wr_i && hit(reg_addr_i, `IPC_OFS_COMM_CTRL))
      comm_nxt = reg_wdata_i;
    if (reg_wr_i && hit(reg_addr_i, `IPC_OFS_PIN_CFG))
      pin_cfg_nxt = reg_wdata_i;
    if (reg_wr_i && hit(reg_addr_i, `IPC_OFS_INT_STATUS))
    begin
      if (individual_clear_enable)
        status_nxt = status_r & ~reg_wdata_i;
      else
        status_nxt = `IPC_RST_STATUS;
    end
    status_nxt = status_nxt | event_set_i;
    rdata_nxt = rdata_r;
    if (reg_rd_i)
    begin
      if (hit(reg_addr_i, `IPC_OFS_COMM_CTRL))
        rdata_nxt = comm_r & `IPC_COMM_RD_MASK;
      else if (hit(reg_addr_i, `IPC_OFS_INT_STATUS))
        rdata_nxt = status_r;
      else
        rdata_nxt = 8'h00;
    end
  end

  // Register file
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      comm_r <= `IPC_RST_COMM;
      pin_cfg_r <= `IPC_RST_PIN;
      status_r <= `IPC_RST_STATUS;
      rdata_r <= 8'h00;
    end
    else
    begin
      comm_r <= comm_nxt;
      pin_cfg_r <= pin_cfg_nxt;
      status_r <= status_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Group requests and pin routing
  assign request_group_a = |(status_r & GROUP_A_MASK[7:0]);
  assign request_group_b = |(status_r & ~GROUP_A_MASK[7:0]);
  assign req_a = irq_pin_swap ? request_group_b : request_group_a;
  assign req_b = irq_pin_swap ? request_group_a : request_group_b;

  // Pin A driver
  ipc_pin_drv u_pin_a (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .req_i(req_a),
    .active_high_i(pin_cfg_r[`IPC_BIT_A_HIGH]),
    .push_pull_i(pin_cfg_r[`IPC_BIT_A_PP]),
    .pin_o(irq_pin_a_o),
    .pin_oe_n_o(irq_pin_a_oe_n_o),
    .asserted_o(a_asserted)
  );

  // Pin B driver
  ipc_pin_drv u_pin_b (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .req_i(req_b),
    .active_high_i(pin_cfg_r[`IPC_BIT_B_HIGH]),
    .push_pull_i(pin_cfg_r[`IPC_BIT_B_PP]),
    .pin_o(irq_pin_b_o),
    .pin_oe_n_o(irq_pin_b_oe_n_o),
    .asserted_o(b_asserted)
  );

  // Serial out pin: driven always in four-wire, on transmit in three-wire
  always_comb
  begin
    sout_nxt = serial_tx_data_i;
    soe_n_nxt = three_wire_enable ? ~serial_tx_en_i : 1'b0;
    srx_nxt = three_wire_enable ? serial_out_pin_i : srx_r;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      sout_r <= 1'b0;
      soe_n_r <= 1'b0;
      srx_r <= 1'b0;
    end
    else
    begin
      sout_r <= sout_nxt;
      soe_n_r <= soe_n_nxt;
      srx_r <= srx_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign serial_out_pin_o = sout_r;
  assign serial_out_pin_oe_n_o = soe_n_r;
  assign serial_rx_data_o = srx_r;
  assign three_wire_enable_o = comm_r[`IPC_BIT_THREE_WIRE];

  // Checks
  AST_SWAP: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    a_asserted == $past(irq_pin_swap ? request_group_b : request_group_a))
    else $error("pin A routing wrong");
  AST_SWAP_B: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    b_asserted == $past(irq_pin_swap ? request_group_a : request_group_b))
    else $error("pin B routing wrong");
  AST_THREE_WIRE: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !$past(three_wire_enable) |-> !serial_out_pin_oe_n_o)
    else $error("four-wire pin not driven");
  AST_CLR_ALL: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    reg_wr_i && hit(reg_addr_i, `IPC_OFS_INT_STATUS)
    && !individual_clear_enable |=> status_r == $past(event_set_i))
    else $error("clear all failed");
  AST_CLR_MASK: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    reg_wr_i && hit(reg_addr_i, `IPC_OFS_INT_STATUS)
    && individual_clear_enable |=> status_r ==
    (($past(status_r) & ~$past(reg_wdata_i)) | $past(event_set_i)))
    else $error("bitmask clear failed");
  AST_RESV_RD: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    reg_rd_i && hit(reg_addr_i, `IPC_OFS_COMM_CTRL)
    |=> reg_rdata_o[1:0] == 2'b00)
    else $error("reserved bits read nonzero");
  AST_A_LEVEL: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    $past(req_a) && $past(pin_cfg_r[`IPC_BIT_A_HIGH]) |-> irq_pin_a_o)
    else $error("pin A polarity wrong");
  AST_A_OD: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !$past(pin_cfg_r[`IPC_BIT_A_PP]) && irq_pin_a_o |-> irq_pin_a_oe_n_o)
    else $error("pin A drove high in open drain");
  AST_B_LEVEL: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    $past(req_b) && !$past(pin_cfg_r[`IPC_BIT_B_HIGH]) |-> !irq_pin_b_o)
    else $error("pin B polarity wrong");
  AST_B_OD: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !$past(pin_cfg_r[`IPC_BIT_B_PP]) && irq_pin_b_o |-> irq_pin_b_oe_n_o)
    else $error("pin B drove high in open drain");
  AST_EVENT: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    |event_set_i |=> (status_r & $past(event_set_i)) == $past(event_set_i))
    else $error("event lost");
  AST_PEND: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    status_r == 8'h00 |=> !a_asserted && !b_asserted)
    else $error("pin asserted with nothing pending");
  COV_SWAP: cover property (@(posedge core_clk_i) irq_pin_swap && a_asserted);
  COV_MASK: cover property (@(posedge core_clk_i)
    individual_clear_enable && reg_wr_i);
  COV_3W: cover property (@(posedge core_clk_i)
    three_wire_enable && serial_tx_en_i);
  COV_B_HIGH: cover property (@(posedge core_clk_i)
    b_asserted && pin_cfg_r[`IPC_BIT_B_HIGH]);
endmodule : ipc_top

// file: verif/ipc_host_model.sv
// Purpose: Host side of the interrupt and serial pins
// Assumes: Pull-ups on both interrupt wires
// Notes: Undriven serial wire shows the inverse of its last driven level
`timescale 1ns/1ns
module ipc_host_model
(
  // Clock
  input wire logic core_clk_i,
  // Device pins
  input wire logic pin_a_i,
  input wire logic pin_a_oe_n_i,
  input wire logic pin_b_i,
  input wire logic pin_b_oe_n_i,
  input wire logic ser_i,
  input wire logic ser_oe_n_i,
  // Host drive of the shared serial wire
  input wire logic host_drv_i,
  input wire logic host_bit_i,
  // Resolved wires
  output logic wire_a_o,
  output logic wire_b_o,
  output logic ser_wire_o
);
  logic last_r = 1'b0;
  // Remember the last level anyone drove on the serial wire
  always_ff @(posedge core_clk_i)
  begin
    if (!ser_oe_n_i || host_drv_i)
      last_r <= ser_wire_o;
  end
  // Pull-ups win when released
  assign wire_a_o = pin_a_oe_n_i ? 1'b1 : pin_a_i;
  assign wire_b_o = pin_b_oe_n_i ? 1'b1 : pin_b_i;
  // Device first, then host, else inverse of the last level
  assign ser_wire_o = !ser_oe_n_i ? ser_i : host_drv_i ? host_bit_i : ~last_r;
endmodule : ipc_host_model

// file: verif/ipc_top_bench.sv
// Purpose: Self-checking bench of the interrupt pin config block
// Assumes: Default group mask, bits 3:0 feed pin a
// Notes: Inputs change 1 ns after the rising edge
`timescale 1ns/1ns
module ipc_top_bench;
  import ipc_pkg::*;
  logic core_clk_i = 1'b0, nrst_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, ev_i = 8'h00, rdata;
  logic tx_d = 1'b0, tx_en = 1'b0, host_drv = 1'b0, host_bit = 1'b0;
  logic ser_o, ser_oe_n, rx_d, tw_en, pa, pa_oe_n, pb, pb_oe_n, wa, wb, ser_w;
  int mismatches = 0, checks_done = 0;
  // Clock generator
  initial forever #5 core_clk_i = ~core_clk_i;
  ipc_top i_dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(rdata), .event_set_i(ev_i),
    .serial_tx_data_i(tx_d), .serial_tx_en_i(tx_en),
    .serial_out_pin_i(ser_w), .serial_out_pin_o(ser_o),
    .serial_out_pin_oe_n_o(ser_oe_n), .serial_rx_data_o(rx_d),
    .three_wire_enable_o(tw_en), .irq_pin_a_o(pa), .irq_pin_a_oe_n_o(pa_oe_n),
    .irq_pin_b_o(pb), .irq_pin_b_oe_n_o(pb_oe_n));
  ipc_host_model i_host (.core_clk_i(core_clk_i), .pin_a_i(pa),
    .pin_a_oe_n_i(pa_oe_n), .pin_b_i(pb), .pin_b_oe_n_i(pb_oe_n),
    .ser_i(ser_o), .ser_oe_n_i(ser_oe_n), .host_drv_i(host_drv),
    .host_bit_i(host_bit), .wire_a_o(wa), .wire_b_o(wb), .ser_wire_o(ser_w));
  task stop_test;
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : tick
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    tick(1);
    reg_wr_i = 1'b0;
    tick(1);
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    tick(1);
    reg_rd_i = 1'b0;
    chk(rdata, exp, "read data");
    tick(1);
  endtask : rd
  task ev(input logic [7:0] v);
    ev_i = v;
    tick(1);
    ev_i = 8'h00;
    tick(1);
  endtask : ev
  task pins(input logic ea, input logic eb);
    chk({7'h00, wa}, {7'h00, ea}, "pin a wire");
    chk({7'h00, wb}, {7'h00, eb}, "pin b wire");
  endtask : pins
  task t_reset;
    rd(8'h31, 8'h00);
    rd(8'h33, 8'h00);
    rd(8'h20, 8'h00);
    pins(1'b1, 1'b1);
    chk({6'h00, pa_oe_n, pb_oe_n}, 8'h03, "released");
  endtask : t_reset
  task t_comm;
    wr(8'h31, 8'h73);
    rd(8'h31, 8'h70);
    chk({7'h00, tw_en}, 8'h01, "three wire");
    wr(8'h31, 8'h00);
  endtask : t_comm
  task t_clear_all;
    ev(8'h01);
    pins(1'b0, 1'b1);
    chk({7'h00, pa_oe_n}, 8'h00, "drain on");
    rd(8'h14, 8'h01);
    wr(8'h14, 8'h00);
    rd(8'h14, 8'h00);
    pins(1'b1, 1'b1);
  endtask : t_clear_all
  task t_swap;
    wr(8'h31, 8'h10);
    ev(8'h10);
    pins(1'b0, 1'b1);
    wr(8'h14, 8'hff);
    ev(8'h01);
    pins(1'b1, 1'b0);
    wr(8'h14, 8'h00);
    wr(8'h31, 8'h00);
  endtask : t_swap
  task t_mask;
    wr(8'h31, 8'h40);
    ev(8'h11);
    wr(8'h14, 8'h01);
    rd(8'h14, 8'h10);
    pins(1'b1, 1'b0);
    wr(8'h14, 8'h10);
    rd(8'h14, 8'h00);
    wr(8'h31, 8'h00);
  endtask : t_mask
  task t_pol;
    wr(8'h33, 8'hcc);
    pins(1'b0, 1'b0);
    chk({6'h00, pa_oe_n, pb_oe_n}, 8'h00, "push pull");
    ev(8'h11);
    pins(1'b1, 1'b1);
    rd(8'h33, 8'h00);
    wr(8'h14, 8'h00);
    pins(1'b0, 1'b0);
    wr(8'h33, 8'h00);
  endtask : t_pol
  task t_three;
    wr(8'h31, 8'h20);
    host_drv = 1'b1;
    host_bit = 1'b1;
    tick(2);
    chk({7'h00, ser_oe_n}, 8'h01, "released");
    chk({7'h00, rx_d}, 8'h01, "rx one");
    host_bit = 1'b0;
    tick(2);
    chk({7'h00, rx_d}, 8'h00, "rx zero");
    host_drv = 1'b0;
    tx_en = 1'b1;
    tx_d = 1'b1;
    tick(2);
    chk({6'h00, ser_oe_n, ser_w}, 8'h01, "tx drive");
    tx_en = 1'b0;
    wr(8'h31, 8'h00);
    tick(1);
    chk({7'h00, ser_oe_n}, 8'h00, "four wire");
    chk({7'h00, ser_w}, 8'h01, "four wire one");
    tx_d = 1'b0;
    tick(1);
    chk({7'h00, ser_w}, 8'h00, "four wire zero");
  endtask : t_three
  // Main sequence
  initial
  begin
    tick(3);
    nrst_i = 1'b1;
    t_reset();
    t_comm();
    t_clear_all();
    t_swap();
    t_mask();
    t_pol();
    t_three();
    stop_test();
  end
endmodule : ipc_top_bench
